// File: bss_defs.svh
/*
 * Constants for the burst and sweep sequencer: trigger sources, burst
 * types, count limits and timing counts. Included by the package.
 */
`ifndef BSS_DEFS_SVH
`define BSS_DEFS_SVH

`define BSS_BURST_MAX        16'd50000
`define BSS_SRC_EXT          2'h0
`define BSS_SRC_TIMER        2'h1
`define BSS_SRC_KEY          2'h2
`define BSS_SRC_BUS          2'h3
`define BSS_TYPE_COUNTED     2'h0
`define BSS_TYPE_INFINITE    2'h1
`define BSS_TYPE_GATED       2'h2
`define BSS_TRIG_OUT_NS      500
`define BSS_CLK_NS           100
`define BSS_TRIG_OUT_CYC     ((`BSS_TRIG_OUT_NS + `BSS_CLK_NS - 1) / `BSS_CLK_NS)

`endif

// File: bss_pkg.sv
/*
 * Types of the burst and sweep sequencer.
 * Assumes bss_defs.svh is on the include path.
 */
`include "bss_defs.svh"

package bss_pkg;
    typedef enum logic [3:0] {
        BSS_IDLE  = 4'b0001,
        BSS_RUN   = 4'b0010,
        BSS_DRAIN = 4'b0100,
        BSS_SWEEP = 4'b1000
    } bss_state_t;
endpackage

// File: bss_edge_sync.sv
/*
 * Two-stage synchroniser with selectable edge detection for the trigger
 * input. Assumes an asynchronous pin on its input and sys_clk domain.
 */
`timescale 1ns/10ps

module bss_edge_sync (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic clk_en,
    input  wire logic pin_in,
    input  wire logic falling_sel,
    output logic      level,
    output logic      edge_pulse
);
    logic meta;
    logic stage2;
    logic prev;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            meta   <= 1'b0;
            stage2 <= 1'b0;
            prev   <= 1'b0;
        end else if (clk_en) begin
            meta   <= pin_in;
            stage2 <= meta;
            prev   <= stage2;
        end
    end

    assign level      = stage2;
    assign edge_pulse = clk_en && (falling_sel ? (prev && !stage2) : (!prev && stage2));
endmodule // bss_edge_sync

// File: bss_sequencer.sv
/*
 * Burst and sweep sequencer: decides when waveform cycles are emitted,
 * drives sync and the trigger output. Assumes a waveform engine that
 * reports cycle_done at the start-phase sample and sweep_done at sweep end.
 */
// Contract
// - Sync goes high at each sweep start
// - Marker off: sync low at sweep midpoint
// - Marker on: sync low at marker frequency
// - Marker accepted only between start and stop
// - Counted burst 1..50000 cycles, trigger started
// - Infinite count runs continuously after trigger
// - Four trigger sources selectable
// - Trigger pin may output internal trigger pulse
// - Bursts start and end at start phase
// - 0 deg first sample, 360 last sample
// - Gated: continuous output while gate asserted
// - Gate off: finish cycle, hold start level
// - Noise gated: stop immediately on gate off
// - Three burst types: counted, infinite, gated
// - Trigger edge polarity selectable
// - External trigger: one sweep per pulse; code ignores the pin edge while trig_out_en is set
// - Internal trigger: sweeps repeat continuously
`timescale 1ns/10ps
`include "bss_defs.svh"

module bss_sequencer
    import bss_pkg::*;
#(
    parameter int REC_W   = 16,
    parameter int FREQ_W  = 32,
    parameter int TIMER_W = 32
) (
    input  wire logic               sys_clk,
    input  wire logic               rstn,
    input  wire logic               clk_en,
    input  wire logic               sweep_mode,
    input  wire logic [1:0]         burst_type,
    input  wire logic [15:0]        burst_count,
    input  wire logic [1:0]         trig_src,
    input  wire logic               trig_falling,
    input  wire logic               trig_out_en,
    input  wire logic               noise_sel,
    input  wire logic               marker_en,
    input  wire logic [FREQ_W-1:0]  start_freq,
    input  wire logic [FREQ_W-1:0]  stop_freq,
    input  wire logic [FREQ_W-1:0]  marker_freq,
    input  wire logic [FREQ_W-1:0]  cur_freq,
    input  wire logic               sweep_half,
    input  wire logic               sweep_done,
    input  wire logic [TIMER_W-1:0] timer_period,
    input  wire logic               key_trig,
    input  wire logic               bus_trig,
    input  wire logic [15:0]        phase_in,
    input  wire logic [REC_W-1:0]   rec_last,
    input  wire logic               cycle_done,
    input  wire logic               trig_pin_in,
    output logic                    trig_pin_out,
    output logic                    trig_pin_oe,
    output logic                    wave_run,
    output logic                    wave_restart,
    output logic [REC_W-1:0]        start_addr,
    output logic                    sync_out,
    output logic                    marker_ok,
    output logic                    busy
);
    localparam int TOC = `BSS_TRIG_OUT_CYC;

    // The phase product is 32 bits wide, so the record index stops at 20 bits
    if (REC_W < 2 || REC_W > 20 || FREQ_W < 1 || TIMER_W < 2) begin : g_bad_param
        $error("bss_sequencer: unsupported parameter values");
    end

    function automatic logic in_range(input logic [FREQ_W-1:0] f,
                                      input logic [FREQ_W-1:0] a,
                                      input logic [FREQ_W-1:0] b);
        in_range = (a <= b) ? (f >= a && f <= b) : (f >= b && f <= a);
    endfunction

    bss_state_t         state;
    logic               gate_lvl;
    logic               ext_edge;
    logic [TIMER_W-1:0] timer_cnt;
    logic               timer_tick;
    logic               trig;
    logic [15:0]        cyc_cnt;
    logic [7:0]         tout_cnt;
    logic               marker_hit;
    logic               gated;

    // ***************************************************************
    // Trigger selection
    // ***************************************************************
    bss_edge_sync u_sync (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .clk_en     (clk_en),
        .pin_in     (trig_pin_in),
        .falling_sel(trig_falling),
        .level      (gate_lvl),
        .edge_pulse (ext_edge)
    );

    assign gated = !sweep_mode && burst_type == `BSS_TYPE_GATED;

    // Internal timer free-runs so its rate does not depend on burst length
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            timer_cnt <= '0;
        end else if (clk_en) begin
            if (timer_tick)
                timer_cnt <= '0;
            else
                timer_cnt <= timer_cnt + TIMER_W'(1);
        end
    end
    assign timer_tick = (timer_cnt >= timer_period);

    always_comb begin
        unique case (trig_src)
            `BSS_SRC_EXT:   trig = ext_edge && !trig_out_en;
            `BSS_SRC_TIMER: trig = timer_tick;
            `BSS_SRC_KEY:   trig = key_trig;
            default:        trig = bus_trig;
        endcase
        if (gated || !clk_en)
            trig = 1'b0;
    end

    // ***************************************************************
    // Trigger output on the shared pin
    // ***************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            tout_cnt     <= '0;
            trig_pin_out <= 1'b0;
            trig_pin_oe  <= 1'b0;
        end else if (clk_en) begin
            trig_pin_oe <= trig_out_en && trig_src != `BSS_SRC_EXT && !gated;
            if (trig && trig_src != `BSS_SRC_EXT) begin
                tout_cnt     <= 8'(TOC);
                trig_pin_out <= 1'b1;
            end else if (tout_cnt > 8'h01) begin
                tout_cnt <= tout_cnt - 8'h01;
            end else begin
                tout_cnt     <= '0;
                trig_pin_out <= 1'b0;
            end
        end
    end

    // ***************************************************************
    // Start phase mapping and marker check
    // ***************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            start_addr <= '0;
            marker_ok  <= 1'b0;
        end else if (clk_en) begin
            // 0 maps to the first sample, 3600 tenths of a degree to the last
            start_addr <= REC_W'((32'(rec_last) * 32'(phase_in > 16'd3600 ? 16'd3600 : phase_in))
                                  / 32'd3600);
            marker_ok  <= in_range(marker_freq, start_freq, stop_freq);
        end
    end

    // ***************************************************************
    // Sequencer
    // ***************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state        <= BSS_IDLE;
            cyc_cnt      <= '0;
            wave_run     <= 1'b0;
            wave_restart <= 1'b0;
            busy         <= 1'b0;
        end else if (clk_en) begin
            wave_restart <= 1'b0;
            unique case (state)
                BSS_IDLE: begin
                    wave_run <= 1'b0;
                    busy     <= 1'b0;
                    if (sweep_mode && (trig || trig_src == `BSS_SRC_TIMER)) begin
                        state        <= BSS_SWEEP;
                        wave_run     <= 1'b1;
                        wave_restart <= 1'b1;
                        busy         <= 1'b1;
                    end else if (gated ? gate_lvl : trig) begin
                        state        <= BSS_RUN;
                        cyc_cnt      <= (burst_count == 16'h0000) ? 16'h0001
                                      : (burst_count > `BSS_BURST_MAX) ? `BSS_BURST_MAX : burst_count;
                        wave_run     <= 1'b1;
                        wave_restart <= 1'b1;
                        busy         <= 1'b1;
                    end
                end
                BSS_RUN: begin
                    // Triggers are not looked at here, so a running burst is never extended
                    if (gated && !gate_lvl) begin
                        if (noise_sel) begin
                            state    <= BSS_IDLE;
                            wave_run <= 1'b0;
                        end else begin
                            state <= BSS_DRAIN;
                        end
                    end else if (burst_type == `BSS_TYPE_COUNTED && !gated && cycle_done) begin
                        if (cyc_cnt == 16'h0001) begin
                            state    <= BSS_IDLE;
                            wave_run <= 1'b0;
                            busy     <= 1'b0;
                        end else begin
                            cyc_cnt <= cyc_cnt - 16'h0001;
                        end
                    end
                    // Infinite count: no exit, runs until reconfigured
                    if (burst_type == `BSS_TYPE_INFINITE || sweep_mode)
                        wave_run <= 1'b1;
                end
                BSS_DRAIN: begin
                    if (cycle_done || noise_sel) begin
                        state    <= BSS_IDLE;
                        wave_run <= 1'b0;
                        busy     <= 1'b0;
                    end
                end
                BSS_SWEEP: begin
                    if (sweep_done) begin
                        state    <= BSS_IDLE;
                        wave_run <= 1'b0;
                        busy     <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ***************************************************************
    // Sync output
    // ***************************************************************
    assign marker_hit = marker_ok && (start_freq <= stop_freq ? cur_freq >= marker_freq
                                                              : cur_freq <= marker_freq);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sync_out <= 1'b0;
        end else if (clk_en) begin
            if (state == BSS_IDLE && sweep_mode && (trig || trig_src == `BSS_SRC_TIMER))
                sync_out <= 1'b1;
            else if (state == BSS_SWEEP && (marker_en ? marker_hit : sweep_half))
                sync_out <= 1'b0;
            else if (state == BSS_SWEEP && sweep_done)
                sync_out <= 1'b0;
        end
    end

    // ***************************************************************
    // Checks
    // ***************************************************************
    property p_sync_start;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && state == BSS_IDLE && sweep_mode && trig) |=> sync_out && state == BSS_SWEEP;
    endproperty
    a_sync_start: assert property (p_sync_start) else $error("sync not raised at sweep start");

    property p_sync_half;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && state == BSS_SWEEP && !marker_en && sweep_half) |=> !sync_out;
    endproperty
    a_sync_half: assert property (p_sync_half) else $error("sync not low at midpoint");

    property p_sync_marker;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && state == BSS_SWEEP && marker_en && marker_hit) |=> !sync_out;
    endproperty
    a_sync_marker: assert property (p_sync_marker) else $error("sync not low at marker");

    property p_marker_range;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && !in_range(marker_freq, start_freq, stop_freq)) |=> !marker_ok;
    endproperty
    a_marker_range: assert property (p_marker_range) else $error("marker outside range accepted");

    property p_burst_trig;
        @(posedge sys_clk) disable iff (!rstn)
        (state == BSS_IDLE && !sweep_mode && !gated && $past(state) == BSS_IDLE) ##1 state == BSS_RUN
            |-> $past(trig);
    endproperty
    a_burst_trig: assert property (p_burst_trig) else $error("burst started without trigger");

    property p_gate_off;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && state == BSS_RUN && gated && !gate_lvl && noise_sel) |=> !wave_run ##1 !wave_run;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("noise not stopped at once");

    property p_drain;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && state == BSS_DRAIN && cycle_done) |=> state == BSS_IDLE && !wave_run;
    endproperty
    a_drain: assert property (p_drain) else $error("gate stop not at cycle end");

    property p_no_retrig;
        @(posedge sys_clk) disable iff (!rstn)
        (clk_en && state == BSS_RUN && trig && !cycle_done) |=> $stable(cyc_cnt);
    endproperty
    a_no_retrig: assert property (p_no_retrig) else $error("trigger changed running burst");

    property p_gate_notrig;
        @(posedge sys_clk) disable iff (!rstn)
        gated |-> !trig;
    endproperty
    a_gate_notrig: assert property (p_gate_notrig) else $error("edge trigger in gated mode");

    c_sweep:  cover property (@(posedge sys_clk) disable iff (!rstn) state == BSS_SWEEP ##1 state == BSS_IDLE);
    c_burst:  cover property (@(posedge sys_clk) disable iff (!rstn) state == BSS_RUN ##1 state == BSS_IDLE);
    c_drain:  cover property (@(posedge sys_clk) disable iff (!rstn) state == BSS_DRAIN);
    c_toutp:  cover property (@(posedge sys_clk) disable iff (!rstn) trig_pin_oe && trig_pin_out);
endmodule // bss_sequencer

// File: bss_far_end.sv
/*
 * Far-side model: waveform engine start-phase marks and trigger instrument.
 * Assumes the bench steers drv_lvl; the sequencer owns the pin while oe is high.
 */
`timescale 1ns/10ps

module bss_far_end #(
    parameter int CYC = 12
) (
    input  wire logic sys_clk,
    input  wire logic wave_run,
    input  wire logic wave_restart,
    input  wire logic trig_pin_out,
    input  wire logic trig_pin_oe,
    input  wire logic drv_lvl,
    output logic      cycle_done,
    output logic      pin_lvl
);
    int cnt = 0;

    // Sequencer drive wins on the shared pin
    assign pin_lvl = (trig_pin_oe === 1'b1) ? trig_pin_out : drv_lvl;

    // One mark per cycle, phase taken from the restart
    initial cycle_done = 1'b0;
    always @(posedge sys_clk) begin
        if (wave_restart === 1'b1 || wave_run !== 1'b1) begin
            cnt <= 0;
            cycle_done <= 1'b0;
        end else begin
            cnt <= (cnt == CYC - 1) ? 0 : cnt + 1;
            cycle_done <= (cnt == CYC - 2);
        end
    end
endmodule // bss_far_end

// File: bss_sequencer_bench.sv
/*
 * Self-checking bench for bss_sequencer: bursts, gating, sweeps, trigger out.
 * Assumes bss_far_end stands for the waveform engine and the trigger instrument.
 */
`timescale 1ns/10ps
`include "bss_defs.svh"

module bss_sequencer_bench;
    // ************************************************************
    // Signals
    // ************************************************************
    logic        sys_clk, rstn, clk_en, sweep_mode, trig_falling, trig_out_en, noise_sel, marker_en;
    logic        sweep_half, sweep_done, key_trig, bus_trig, drv_lvl, cycle_done, pin_lvl;
    logic        trig_pin_out, trig_pin_oe, wave_run, wave_restart, sync_out, marker_ok, busy;
    logic [1:0]  burst_type, trig_src;
    logic [15:0] burst_count, phase_in, rec_last, start_addr;
    logic [31:0] start_freq, stop_freq, marker_freq, cur_freq, timer_period;
    int          error_cnt, checked, rst_cnt, seed;
    int          exp_q[$];

    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (wave_restart === 1'b1) rst_cnt++;

    bss_sequencer dut (.sys_clk, .rstn, .clk_en, .sweep_mode, .burst_type, .burst_count, .trig_src,
        .trig_falling, .trig_out_en, .noise_sel, .marker_en, .start_freq, .stop_freq, .marker_freq,
        .cur_freq, .sweep_half, .sweep_done, .timer_period, .key_trig, .bus_trig, .phase_in, .rec_last,
        .cycle_done, .trig_pin_in(pin_lvl), .trig_pin_out, .trig_pin_oe, .wave_run, .wave_restart,
        .start_addr, .sync_out, .marker_ok, .busy);
    bss_far_end far (.sys_clk, .wave_run, .wave_restart, .trig_pin_out, .trig_pin_oe, .drv_lvl,
        .cycle_done, .pin_lvl);

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t ns: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("Counts: %0d checked, %0d mismatched", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    function automatic logic sig(input int w);
        case (w)
            0: return busy;
            1: return wave_run;
            2: return sync_out;
            3: return trig_pin_out;
            4: return cycle_done;
            default: return marker_ok;
        endcase
    endfunction

    // Bounded wait; running out is a mismatch and ends the run
    task automatic wait_sig(input int w, input logic v, input int bound);
        for (int k = 0; k < bound; k++) begin
            @(negedge sys_clk);
            if (sig(w) === v) break;
        end
        check(sig(w), v);
        if (sig(w) !== v) test_done();
    endtask

    task automatic pulse(input int w);
        @(posedge sys_clk);
        if (w == 0) key_trig <= 1'b1;
        else if (w == 1) bus_trig <= 1'b1;
        else if (w == 2) sweep_half <= 1'b1;
        else sweep_done <= 1'b1;
        @(posedge sys_clk);
        {key_trig, bus_trig, sweep_half, sweep_done} <= 4'h0;
    endtask

    // Pin pulse is 300 ns, wider than the minimum the input needs
    task automatic fire(input int src);
        if (src == 0) begin
            @(posedge sys_clk);
            drv_lvl <= ~trig_falling;
            repeat (3) @(posedge sys_clk);
            drv_lvl <= trig_falling;
        end else if (src > 1) begin
            pulse(src - 2);
        end
    endtask

    task automatic burst(input int src, input int n, input bit extra);
        int k, seen, r0;
        trig_src <= 2'h2;
        wait_sig(0, 1'b0, 2000);
        @(posedge sys_clk);
        trig_src <= src[1:0];
        burst_count <= n[15:0];
        exp_q.push_back(n == 0 ? 1 : (n > 50000 ? 50000 : n));
        r0 = rst_cnt;
        fire(src);
        wait_sig(0, 1'b1, 40);
        if (extra) fire(src);
        seen = 0;
        for (k = 0; k < 3000 && busy === 1'b1; k++) begin
            if (cycle_done === 1'b1) seen++;
            @(negedge sys_clk);
        end
        check(seen, exp_q.pop_front());
        check(rst_cnt - r0, 1);
        check(k < 3000, 1);
        if (k == 3000) test_done();
    endtask

    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        int i, k, r0;
        int phases[3];
        phases = '{3600, 1800, 0};
        {sys_clk, rstn, sweep_mode, trig_falling, trig_out_en, noise_sel, marker_en} = 7'h00;
        {sweep_half, sweep_done, key_trig, bus_trig, drv_lvl} = 5'h00;
        {error_cnt, checked, rst_cnt, seed} = {32'h0, 32'h0, 32'h0, 32'h12};
        clk_en = 1'b1;
        burst_type = 2'h0;
        trig_src = 2'h2;
        burst_count = 16'h0001;
        phase_in = 16'h0000;
        rec_last = 16'h03e7;
        {start_freq, stop_freq, marker_freq, cur_freq} = {32'h64, 32'hc8, 32'h96, 32'h64};
        timer_period = 32'h7;
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        for (i = 0; i < 4; i++) burst(i, 3, 1'b1);
        burst(2, 0, 1'b0);
        for (i = 0; i < 4; i++) burst(3, 1 + int'($unsigned($random(seed)) % 5), 1'b0);
        trig_falling <= 1'b1;
        drv_lvl <= 1'b1;
        burst(0, 2, 1'b0);
        for (i = 0; i < 3; i++) begin
            phase_in <= 16'(phases[i]);
            burst(2, 1, 1'b0);
            check(start_addr, 999 * phases[i] / 3600);
        end
        $display("Counted bursts done");
        trig_out_en <= 1'b1;
        pulse(0);
        wait_sig(3, 1'b1, 3);
        check(trig_pin_oe, 1);
        for (k = 0; k < 20 && trig_pin_out === 1'b1; k++) @(negedge sys_clk);
        check(k, `BSS_TRIG_OUT_CYC);
        wait_sig(0, 1'b0, 200);
        trig_out_en <= 1'b0;
        {trig_falling, drv_lvl} <= 2'h0;
        burst_type <= 2'h1;
        pulse(0);
        repeat (60) @(negedge sys_clk);
        check(wave_run, 1);
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        @(negedge sys_clk);
        check({wave_run, busy, sync_out, trig_pin_oe}, 0);
        $display("Trigger output and infinite burst done");
        burst_type <= 2'h2;
        // Key source selected so that the ignored key pulse would start a burst otherwise
        trig_src <= 2'h2;
        for (i = 0; i < 2; i++) begin
            noise_sel <= i[0];
            pulse(0);
            repeat (4) @(negedge sys_clk);
            check(wave_run, 0);
            @(posedge sys_clk);
            drv_lvl <= 1'b1;
            wait_sig(1, 1'b1, 8);
            wait_sig(4, 1'b1, 20);
            @(posedge sys_clk);
            drv_lvl <= 1'b0;
            for (k = 0; k < 40 && wave_run === 1'b1; k++) @(negedge sys_clk);
            check(k < 40, 1);
            check(k <= 6, i);
        end
        {noise_sel, burst_type, sweep_mode, trig_src} <= 6'h06;
        $display("Gated bursts done");
        pulse(0);
        wait_sig(2, 1'b1, 3);
        pulse(2);
        wait_sig(2, 1'b0, 2);
        pulse(3);
        marker_en <= 1'b1;
        wait_sig(5, 1'b1, 3);
        pulse(0);
        wait_sig(2, 1'b1, 3);
        cur_freq <= 32'h80;
        repeat (3) @(negedge sys_clk);
        check(sync_out, 1);
        cur_freq <= 32'h96;
        wait_sig(2, 1'b0, 3);
        pulse(3);
        marker_freq <= 32'hfa;
        wait_sig(5, 1'b0, 3);
        {marker_en, trig_src} <= 3'h0;
        r0 = rst_cnt;
        fire(0);
        repeat (8) @(negedge sys_clk);
        check(rst_cnt - r0, 1);
        pulse(3);
        trig_src <= 2'h1;
        r0 = rst_cnt;
        for (i = 0; i < 3; i++) begin
            repeat (6) @(negedge sys_clk);
            pulse(3);
        end
        repeat (3) @(negedge sys_clk);
        check(rst_cnt - r0 >= 3, 1);
        $display("Sweeps done");
        test_done();
    end
endmodule // bss_sequencer_bench
